// ---- common/adc_link_params.svh ----
`ifndef ADC_LINK_PARAMS_SVH
`define ADC_LINK_PARAMS_SVH

// ==========================================================
// Timing
`define SYS_CLK_HZ 250000000
`define INT_OSC_HZ 307200
`define INT_OSC_DIV (`SYS_CLK_HZ / `INT_OSC_HZ)
`define CONV_TICKS_1X 41036
`define CONV_TICKS_2X 20556
`define ISCK_HZ 38400
`define ISCK_PERIOD (`SYS_CLK_HZ / `ISCK_HZ)
`define EXT_OSC_MIN_HZ 10000
`define EXT_OSC_TIMEOUT (`SYS_CLK_HZ / `EXT_OSC_MIN_HZ)
`define HOST_SCK_HZ 1000000
`define HOST_SCK_HALF (`SYS_CLK_HZ / (2 * `HOST_SCK_HZ))
`define EOSC_50HZ_HZ 256000
`define EOSC_60HZ_HZ 307200
`define EOSC_5060_HZ 280000
`define EOSC_HALF(f) (`SYS_CLK_HZ / (2 * (f)))
`define CS_GAP 16'h0010
`define BOOT_SAMPLE 3'h4
`define BOOT_DONE 3'h5

// ==========================================================
// Frame and configuration layout
`define FRAME_BITS 6'h20
`define CFG_BITS 6'h10
`define CFG_PREAMBLE 3'h5
`define CFG_PRE_MSB 15
`define CFG_PRE_LSB 13
`define CFG_CH_MSB 12
`define CFG_CH_LSB 8
`define CFG_EN2_BIT 7
`define CFG_MODE_MSB 6
`define CFG_MODE_LSB 3
`define CFG_RESET 9'h000
`define COM_SEL 5'h10
`define NEG_RESET 5'h01

// ==========================================================
// Result coding
`define RES_POS_FS 26'h1000000
`define RES_NEG_FS 26'h3000000
`define RES_OVER 25'h1000000
`define RES_UNDER 25'h0FFFFFF

`endif

// ---- common/adc_link_pkg.sv ----
package adc_link_pkg;

  // ==========================================================
  // States
  typedef enum logic [1:0] {
    DEV_CONV = 2'b00,
    DEV_SLEEP = 2'b01,
    DEV_DIO = 2'b10
  } dev_state_e;

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_POLL = 2'b01,
    HOST_SHIFT = 2'b10,
    HOST_PUSH = 2'b11
  } host_state_e;

  // ==========================================================
  // Configuration word held by the device
  typedef struct packed {
    logic sgl;
    logic odd;
    logic [2:0] addr;
    logic temp;
    logic [1:0] rej;
    logic spd;
  } adc_cfg_s;

  typedef struct packed {
    dev_state_e state;
    adc_cfg_s cfg;
    logic [2:0] cs_sync;
    logic [2:0] sck_sync;
    logic [2:0] sdi_sync;
    logic [2:0] fclk_sync;
    logic cs_f;
    logic sck_f;
    logic sdi_f;
    logic fclk_f;
    logic [2:0] boot_cnt;
    logic int_mode;
    logic [15:0] osc_cnt;
    logic [15:0] act_cnt;
    logic ext_active;
    logic [15:0] conv_cnt;
    logic [15:0] isck_cnt;
    logic [5:0] bit_cnt;
    logic [15:0] cfg_sh;
    logic [31:0] shreg;
    logic dev_sdo;
    logic dev_sdo_oe_n;
    logic dev_sck;
    logic dev_sck_oe_n;
    logic [4:0] pos_sel;
    logic [4:0] neg_sel;
    logic converting;
  } dev_reg_s;

  typedef struct packed {
    host_state_e state;
    logic cs_n;
    logic sck_o;
    logic sck_oe_n;
    logic sdi;
    logic fclk;
    logic ext_mode;
    logic [2:0] sdo_sync;
    logic [2:0] sck_sync;
    logic sdo_f;
    logic sck_f;
    logic [15:0] fclk_cnt;
    logic [15:0] sck_cnt;
    logic [5:0] bit_cnt;
    logic [31:0] tx;
    logic [31:0] rx;
  } host_reg_s;

endpackage

// ---- common/adc_link_if.sv ----
`timescale 1ns/1ns
`default_nettype none

interface adc_link_if;
  logic cs_n;
  logic sdi;
  logic fclk;
  logic dev_sdo;
  logic dev_sdo_oe_n;
  logic dev_sck;
  logic dev_sck_oe_n;
  logic host_sck;
  logic host_sck_oe_n;
  logic sdo;
  logic sck;

  // Undriven lines float high, as with a pull-up on the board
  assign sdo = !dev_sdo_oe_n ? dev_sdo : 1'b1;
  assign sck = !dev_sck_oe_n ? dev_sck :
               (!host_sck_oe_n ? host_sck : 1'b1);

  modport device (
    input cs_n, sdi, fclk, sck,
    output dev_sdo, dev_sdo_oe_n, dev_sck, dev_sck_oe_n
  );

  modport host (
    input sdo, sck,
    output cs_n, sdi, fclk, host_sck, host_sck_oe_n
  );
endinterface

`default_nettype wire

// ---- hdl/adc_link_device.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "adc_link_params.svh"

module adc_link_device #(
  parameter logic [15:0] CONV_TICKS_1X = 16'(`CONV_TICKS_1X),
  parameter logic [15:0] CONV_TICKS_2X = 16'(`CONV_TICKS_2X),
  parameter logic [15:0] ISCK_PERIOD = 16'(`ISCK_PERIOD),
  parameter logic [15:0] EXT_OSC_TIMEOUT = 16'(`EXT_OSC_TIMEOUT)
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  adc_link_if.device link,
  input wire logic [25:0] sample_i,
  output logic [4:0] mux_pos_sel_o,
  output logic [4:0] mux_neg_sel_o,
  output logic temp_sel_o,
  output logic [1:0] rejection_o,
  output logic speed_2x_o,
  output logic converting_o,
  output logic int_sck_mode_o,
  output logic ext_conv_clk_o
);

  localparam logic [15:0] OSC_DIV = 16'(`INT_OSC_DIV);

  adc_link_pkg::dev_reg_s q;
  adc_link_pkg::dev_reg_s n;
  logic cs_fall;
  logic cs_rise;
  logic osc_tick;
  logic fclk_rise;
  logic conv_tick;
  logic tgl;
  logic rise;
  logic fall;
  logic start_conv;
  logic [15:0] target;
  logic [15:0] isck_half;
  logic [31:0] result;

  // ==========================================================
  // Next state
  always_comb begin
    n = q;
    tgl = 1'b0;
    osc_tick = 1'b0;
    start_conv = 1'b0;
    isck_half = ISCK_PERIOD >> 1;

    // Pins from the host: three stages, change taken on agreement
    n.cs_sync = {q.cs_sync[1:0], link.cs_n};
    n.sck_sync = {q.sck_sync[1:0], link.sck};
    n.sdi_sync = {q.sdi_sync[1:0], link.sdi};
    n.fclk_sync = {q.fclk_sync[1:0], link.fclk};
    if (q.cs_sync[1] == q.cs_sync[2]) begin
      n.cs_f = q.cs_sync[2];
    end
    if (q.sck_sync[1] == q.sck_sync[2]) begin
      n.sck_f = q.sck_sync[2];
    end
    if (q.sdi_sync[1] == q.sdi_sync[2]) begin
      n.sdi_f = q.sdi_sync[2];
    end
    if (q.fclk_sync[1] == q.fclk_sync[2]) begin
      n.fclk_f = q.fclk_sync[2];
    end
    cs_fall = q.cs_f & ~n.cs_f;
    cs_rise = ~q.cs_f & n.cs_f;

    // Mode strap: sampled once the pipeline has settled after reset, and again at each select fall
    if (q.boot_cnt != `BOOT_DONE) begin
      n.boot_cnt = q.boot_cnt + 3'h1;
    end
    if (q.boot_cnt == `BOOT_SAMPLE || cs_fall) begin
      n.int_mode = q.sck_f;
    end

    // ==========================================================
    // Conversion clock
    if (q.osc_cnt == OSC_DIV - 16'h0001) begin
      n.osc_cnt = 16'h0000;
      osc_tick = 1'b1;
    end else begin
      n.osc_cnt = q.osc_cnt + 16'h0001;
    end
    // A pin that stops toggling falls back to the oscillator
    fclk_rise = ~q.fclk_f & n.fclk_f;
    if (fclk_rise) begin
      n.act_cnt = 16'h0000;
      n.ext_active = 1'b1;
    end else if (q.act_cnt == EXT_OSC_TIMEOUT) begin
      n.ext_active = 1'b0;
    end else begin
      n.act_cnt = q.act_cnt + 16'h0001;
    end
    conv_tick = q.ext_active ? fclk_rise : osc_tick;
    target = q.cfg.spd ? CONV_TICKS_2X : CONV_TICKS_1X;

    // ==========================================================
    // Serial clock source
    if (q.state == adc_link_pkg::DEV_DIO && q.int_mode) begin
      if (q.isck_cnt == isck_half - 16'h0001) begin
        n.isck_cnt = 16'h0000;
        tgl = 1'b1;
        n.dev_sck = ~q.dev_sck;
      end else begin
        n.isck_cnt = q.isck_cnt + 16'h0001;
      end
    end
    if (q.int_mode) begin
      rise = tgl & ~q.dev_sck;
      fall = tgl & q.dev_sck;
    end else begin
      rise = ~q.sck_f & n.sck_f;
      fall = q.sck_f & ~n.sck_f;
    end

    // Result word, with out-of-range inputs flagged
    result = {2'b00, ~sample_i[25], sample_i[24:0], 4'h0};
    if ($signed(sample_i) >= $signed(`RES_POS_FS)) begin
      result = {2'b00, 1'b1, `RES_OVER, 4'h0};
    end else if ($signed(sample_i) < $signed(`RES_NEG_FS)) begin
      result = {2'b00, 1'b0, `RES_UNDER, 4'h0};
    end

    // ==========================================================
    // Operating cycle
    unique case (q.state)
      adc_link_pkg::DEV_CONV: begin
        if (conv_tick) begin
          if (q.conv_cnt >= target - 16'h0001) begin
            n.state = adc_link_pkg::DEV_SLEEP;
            n.shreg = result;
          end else begin
            n.conv_cnt = q.conv_cnt + 16'h0001;
          end
        end
      end
      adc_link_pkg::DEV_SLEEP: begin
        if (!q.cs_f) begin
          n.state = adc_link_pkg::DEV_DIO;
          n.bit_cnt = 6'h00;
          n.isck_cnt = 16'h0000;
          n.dev_sck = 1'b1;
          n.cfg_sh = 16'h0000;
        end
      end
      adc_link_pkg::DEV_DIO: begin
        if (cs_rise) begin
          if (q.bit_cnt == 6'h00) begin
            n.state = adc_link_pkg::DEV_SLEEP;
          end else begin
            start_conv = 1'b1;
          end
        end else begin
          if (fall && q.bit_cnt != 6'h00) begin
            n.shreg = {q.shreg[30:0], 1'b0};
          end
          if (rise) begin
            if (q.bit_cnt < `CFG_BITS) begin
              n.cfg_sh = {q.cfg_sh[14:0], n.sdi_f};
            end
            n.bit_cnt = q.bit_cnt + 6'h01;
            if (q.bit_cnt == `FRAME_BITS - 6'h01) begin
              start_conv = 1'b1;
            end
          end
        end
      end
      default: begin
        n.state = adc_link_pkg::DEV_CONV;
      end
    endcase

    // New settings take hold at the very next conversion
    if (start_conv) begin
      n.state = adc_link_pkg::DEV_CONV;
      n.conv_cnt = 16'h0000;
      if (n.bit_cnt >= `CFG_BITS) begin
        if (n.cfg_sh[`CFG_PRE_MSB:`CFG_PRE_LSB] == `CFG_PREAMBLE) begin
          n.cfg[8:4] = n.cfg_sh[`CFG_CH_MSB:`CFG_CH_LSB];
        end
        if (n.cfg_sh[`CFG_EN2_BIT]) begin
          n.cfg[3:0] = n.cfg_sh[`CFG_MODE_MSB:`CFG_MODE_LSB];
        end
      end
    end

    // ==========================================================
    // Channel routing and pin drive
    n.pos_sel = {1'b0, n.cfg.addr, n.cfg.odd};
    if (n.cfg.sgl) begin
      n.neg_sel = `COM_SEL;
    end else begin
      n.neg_sel = {1'b0, n.cfg.addr, ~n.cfg.odd};
    end
    if (n.state == adc_link_pkg::DEV_DIO) begin
      n.dev_sdo = n.shreg[31];
    end else begin
      n.dev_sdo = (n.state == adc_link_pkg::DEV_CONV);
    end
    n.dev_sdo_oe_n = n.cs_f;
    n.dev_sck_oe_n = !(n.state == adc_link_pkg::DEV_DIO && n.int_mode);
    n.converting = (n.state == adc_link_pkg::DEV_CONV);

    if (!rst_n_i) begin
      n = '0;
      n.state = adc_link_pkg::DEV_CONV;
      n.cfg = `CFG_RESET;
      n.neg_sel = `NEG_RESET;
      n.cs_sync = 3'h7;
      n.cs_f = 1'b1;
      // Clock line idles high on its pull-up: no false edge after reset
      n.sck_sync = 3'h7;
      n.sck_f = 1'b1;
      n.dev_sdo_oe_n = 1'b1;
      n.dev_sck = 1'b1;
      n.dev_sck_oe_n = 1'b1;
      n.converting = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    q <= n;
  end

  // ==========================================================
  // Outputs
  assign link.dev_sdo = q.dev_sdo;
  assign link.dev_sdo_oe_n = q.dev_sdo_oe_n;
  assign link.dev_sck = q.dev_sck;
  assign link.dev_sck_oe_n = q.dev_sck_oe_n;
  assign mux_pos_sel_o = q.pos_sel;
  assign mux_neg_sel_o = q.neg_sel;
  assign temp_sel_o = q.cfg.temp;
  assign rejection_o = q.cfg.rej;
  assign speed_2x_o = q.cfg.spd;
  assign converting_o = q.converting;
  assign int_sck_mode_o = q.int_mode;
  assign ext_conv_clk_o = q.ext_active;

endmodule

`default_nettype wire

// ---- hdl/adc_link_host.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "adc_link_params.svh"

// Shift-style FIFO: the head always sits in a flip-flop
module adc_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [CW-1:0] cnt;
    logic valid;
    logic ready;
  } fifo_reg_s;

  fifo_reg_s q;
  fifo_reg_s n;
  logic push;
  logic pop;
  logic [CW-1:0] idx;

  always_comb begin
    n = q;
    pop = q.valid & out_ready_i;
    push = in_valid_i & q.ready;
    idx = q.cnt - CW'(pop);
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        n.mem[i] = q.mem[i + 1];
      end
    end
    if (push) begin
      n.mem[idx] = in_data_i;
    end
    n.cnt = q.cnt + CW'(push) - CW'(pop);
    n.valid = (n.cnt != '0);
    n.ready = (n.cnt != CW'(DEPTH));
    if (!rst_n_i) begin
      n = '0;
      n.ready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    q <= n;
  end

  assign in_ready_o = q.ready;
  assign out_valid_o = q.valid;
  assign out_data_o = q.mem[0];
endmodule

module adc_link_host (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  adc_link_if.host link,
  input wire logic read_en_i,
  input wire logic ext_sck_i,
  input wire logic [15:0] cfg_i,
  input wire logic [1:0] conv_clk_sel_i,
  output logic [31:0] word_o,
  output logic word_valid_o,
  input wire logic word_ready_i
);
  localparam logic [15:0] SCK_HALF = 16'(`HOST_SCK_HALF);

  adc_link_pkg::host_reg_s q;
  adc_link_pkg::host_reg_s n;
  logic fifo_ready;
  logic tgl;
  logic rise;
  logic fall;
  logic [15:0] fhalf;

  always_comb begin
    n = q;
    tgl = 1'b0;
    n.sdo_sync = {q.sdo_sync[1:0], link.sdo};
    n.sck_sync = {q.sck_sync[1:0], link.sck};
    if (q.sdo_sync[1] == q.sdo_sync[2]) begin
      n.sdo_f = q.sdo_sync[2];
    end
    if (q.sck_sync[1] == q.sck_sync[2]) begin
      n.sck_f = q.sck_sync[2];
    end

    // ==========================================================
    // Conversion clock for the device
    unique case (conv_clk_sel_i)
      2'h1: fhalf = 16'(`EOSC_HALF(`EOSC_50HZ_HZ));
      2'h2: fhalf = 16'(`EOSC_HALF(`EOSC_60HZ_HZ));
      2'h3: fhalf = 16'(`EOSC_HALF(`EOSC_5060_HZ));
      2'h0: fhalf = 16'h0000;
    endcase
    if (conv_clk_sel_i == 2'h0) begin
      n.fclk = 1'b0;
      n.fclk_cnt = 16'h0000;
    end else if (q.fclk_cnt >= fhalf - 16'h0001) begin
      n.fclk = ~q.fclk;
      n.fclk_cnt = 16'h0000;
    end else begin
      n.fclk_cnt = q.fclk_cnt + 16'h0001;
    end

    // ==========================================================
    // Serial clock edges
    if (q.state == adc_link_pkg::HOST_SHIFT && q.ext_mode) begin
      if (q.sck_cnt == SCK_HALF - 16'h0001) begin
        n.sck_cnt = 16'h0000;
        n.sck_o = ~q.sck_o;
        tgl = 1'b1;
      end else begin
        n.sck_cnt = q.sck_cnt + 16'h0001;
      end
    end
    if (q.ext_mode) begin
      rise = tgl & ~q.sck_o;
      fall = tgl & q.sck_o;
    end else begin
      rise = ~q.sck_f & n.sck_f;
      fall = q.sck_f & ~n.sck_f;
    end

    unique case (q.state)
      adc_link_pkg::HOST_IDLE: begin
        // Clock level is set before select falls, it picks the mode
        n.cs_n = 1'b1;
        n.sck_o = 1'b0;
        n.sck_oe_n = ~ext_sck_i;
        if (q.sck_cnt != `CS_GAP) begin
          n.sck_cnt = q.sck_cnt + 16'h0001;
        end else if (read_en_i && fifo_ready
                     && q.sck_oe_n == ~ext_sck_i) begin
          n.state = adc_link_pkg::HOST_POLL;
          n.cs_n = 1'b0;
          n.ext_mode = ext_sck_i;
          n.tx = {cfg_i, 16'h0000};
          n.sdi = cfg_i[15];
          n.bit_cnt = 6'h00;
          n.sck_cnt = 16'h0000;
        end
      end
      adc_link_pkg::HOST_POLL: begin
        if (!q.sdo_f) begin
          n.state = adc_link_pkg::HOST_SHIFT;
        end
      end
      adc_link_pkg::HOST_SHIFT: begin
        if (fall && q.bit_cnt != 6'h00) begin
          n.tx = {q.tx[30:0], 1'b0};
          n.sdi = q.tx[30];
        end
        if (rise) begin
          n.rx = {q.rx[30:0], q.sdo_f};
          n.bit_cnt = q.bit_cnt + 6'h01;
          if (q.bit_cnt == `FRAME_BITS - 6'h01) begin
            n.state = adc_link_pkg::HOST_PUSH;
          end
        end
      end
      adc_link_pkg::HOST_PUSH: begin
        n.cs_n = 1'b1;
        if (fifo_ready) begin
          n.state = adc_link_pkg::HOST_IDLE;
          n.sck_cnt = 16'h0000;
        end
      end
    endcase

    if (!rst_n_i) begin
      n = '0;
      n.state = adc_link_pkg::HOST_IDLE;
      n.cs_n = 1'b1;
      n.sck_oe_n = 1'b1;
      n.sdo_sync = 3'h7;
      n.sdo_f = 1'b1;
      n.sck_sync = 3'h7;
      n.sck_f = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    q <= n;
  end

  // Full FIFO holds off the next read, so no word is ever dropped
  adc_word_fifo #(
    .WIDTH(32),
    .DEPTH(8)
  ) adc_word_fifo_i (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(q.state == adc_link_pkg::HOST_PUSH),
    .in_data_i(q.rx),
    .in_ready_o(fifo_ready),
    .out_valid_o(word_valid_o),
    .out_data_o(word_o),
    .out_ready_i(word_ready_i)
  );

  assign link.cs_n = q.cs_n;
  assign link.sdi = q.sdi;
  assign link.fclk = q.fclk;
  assign link.host_sck = q.sck_o;
  assign link.host_sck_oe_n = q.sck_oe_n;

endmodule

`default_nettype wire

// ---- sim/adc_link_props.sv ----
`timescale 1ns/1ns
`default_nettype none

module adc_link_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic fclk,
  input wire logic dev_sdo,
  input wire logic dev_sdo_oe_n,
  input wire logic dev_sck,
  input wire logic dev_sck_oe_n,
  input wire logic host_sck,
  input wire logic host_sck_oe_n,
  input wire logic sdo,
  input wire logic sck
);
  logic [5:0] rise_cnt;
  logic cs_q;
  logic sck_q;
  logic mode_int;
  logic sck_rise;

  // ==========================================================
  // Helpers
  // A rise made by the pull-up after a release is not a clock bit
  assign sck_rise = sck && !sck_q && !(dev_sck_oe_n && host_sck_oe_n);

  always_ff @(posedge clk_sys_i) begin
    cs_q <= cs_n;
    sck_q <= sck;
    if (!rst_n_i || cs_n) begin
      rise_cnt <= 6'h00;
    end else if (sck_rise && rise_cnt != 6'h3F) begin
      rise_cnt <= rise_cnt + 6'h01;
    end
    if (!rst_n_i) begin
      mode_int <= 1'b1;
    end else if (!cs_n && cs_q) begin
      mode_int <= sck;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  cs_high_hiz_a: assert property (cs_n [*8] |-> dev_sdo_oe_n)
    else $error("sdo driven while select high");
  cs_low_drive_a: assert property ($fell(cs_n) |-> ##[2:8] !dev_sdo_oe_n)
    else $error("sdo not driven after select fall");
  sck_contention_a: assert property (dev_sck_oe_n || host_sck_oe_n)
    else $error("both ends drive sck");
  sck_release_a: assert property (cs_n [*8] |-> dev_sck_oe_n)
    else $error("device drives sck while select high");
  ext_mode_quiet_a: assert property (!cs_n && !mode_int |-> dev_sck_oe_n)
    else $error("device drives sck in external mode");
  sdo_hold_a: assert property (sck_rise && !cs_n |-> $stable(dev_sdo) [*3])
    else $error("sdo moved at a rising sck");
  sdi_hold_a: assert property (sck_rise && !cs_n |-> ##1 $stable(sdi) [*3])
    else $error("sdi moved at a rising sck");
  bit_limit_a: assert property (!cs_n |-> rise_cnt <= 6'h20)
    else $error("more than 32 sck rises in a frame");
  isck_half_a: assert property (
    $changed(dev_sck) && !dev_sck_oe_n |=> $stable(dev_sck) [*8])
    else $error("internal sck half period too short");
  frame_end_a: assert property (
    sck_rise && rise_cnt == 6'h1F |-> ##[2:12] sdo)
    else $error("no busy status after the last bit");

  cover property ($fell(cs_n) && sck);
  cover property ($fell(cs_n) && !sck);
  cover property (sck_rise && rise_cnt == 6'h1F);
  cover property ($rose(fclk));
  cover property ($rose(host_sck) && !host_sck_oe_n);
endmodule

`default_nettype wire

// ---- sim/adc_serial_conversion_control_bench.sv ----
`timescale 1ns/1ns
`default_nettype none

module adc_serial_conversion_control_bench;
  // ==========================================================
  // Signals
  logic clk_sys_i;
  logic rst_n_i;
  logic read_en_i;
  logic ext_sck_i;
  logic [15:0] cfg_i;
  logic [1:0] conv_clk_sel_i;
  logic word_ready_i;
  logic [25:0] sample_i;
  logic [31:0] word_o;
  logic word_valid_o;
  logic [4:0] mux_pos_sel_o;
  logic [4:0] mux_neg_sel_o;
  logic temp_sel_o;
  logic [1:0] rejection_o;
  logic speed_2x_o;
  logic converting_o;
  logic int_sck_mode_o;
  logic ext_conv_clk_o;
  logic [31:0] seed;
  logic [31:0] exp_q[$];
  logic fclk_q;
  int fclk_cnt;
  int fclk_per;
  int n_fail;
  int comparisons;

  adc_link_if link ();

  // Short counts keep each read a few thousand cycles long
  adc_link_device #(
    .CONV_TICKS_1X(16'h0004),
    .CONV_TICKS_2X(16'h0002),
    .ISCK_PERIOD(16'h0040),
    .EXT_OSC_TIMEOUT(16'h04B0)
  ) adc_link_device_i (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .link(link),
    .sample_i(sample_i),
    .mux_pos_sel_o(mux_pos_sel_o),
    .mux_neg_sel_o(mux_neg_sel_o),
    .temp_sel_o(temp_sel_o),
    .rejection_o(rejection_o),
    .speed_2x_o(speed_2x_o),
    .converting_o(converting_o),
    .int_sck_mode_o(int_sck_mode_o),
    .ext_conv_clk_o(ext_conv_clk_o)
  );

  adc_link_host adc_link_host_i (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .link(link),
    .read_en_i(read_en_i),
    .ext_sck_i(ext_sck_i),
    .cfg_i(cfg_i),
    .conv_clk_sel_i(conv_clk_sel_i),
    .word_o(word_o),
    .word_valid_o(word_valid_o),
    .word_ready_i(word_ready_i)
  );

  adc_link_props adc_link_props_i (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .cs_n(link.cs_n),
    .sdi(link.sdi),
    .fclk(link.fclk),
    .dev_sdo(link.dev_sdo),
    .dev_sdo_oe_n(link.dev_sdo_oe_n),
    .dev_sck(link.dev_sck),
    .dev_sck_oe_n(link.dev_sck_oe_n),
    .host_sck(link.host_sck),
    .host_sck_oe_n(link.host_sck_oe_n),
    .sdo(link.sdo),
    .sck(link.sck)
  );

  // ==========================================================
  // Model and helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] fmt(input logic [25:0] s);
    int v;
    v = $signed(s);
    if (v >= 16777216) begin
      return {3'b001, 25'h1000000, 4'h0};
    end
    if (v < -16777216) begin
      return {3'b000, 25'h0FFFFFF, 4'h0};
    end
    return {2'b00, ~s[25], s[24:0], 4'h0};
  endfunction

  function automatic logic in_tol(input int per, input logic [1:0] sel);
    int e;
    e = 250000000 / ((sel == 2'h1) ? 256000 :
                     (sel == 2'h2) ? 307200 : 280000);
    return per * 50 >= e * 49 && per * 50 <= e * 51;
  endfunction

  task automatic report_and_stop();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_val(input string name, input logic [31:0] exp,
                           input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp,
                           input logic got);
    check_val(name, 32'(exp), 32'(got));
  endtask

  task automatic wait_cs(input logic lvl);
    int i;
    for (i = 0; i < 40000 && link.cs_n !== lvl; i++) begin
      @(negedge clk_sys_i);
    end
    if (link.cs_n !== lvl) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  // Inputs for read k: sample, config, sck mode, conversion clock
  task automatic next_in(input int k);
    logic [25:0] s;
    seed = lfsr(seed);
    s = (k == 2) ? 26'h1800000 : (k == 5) ? 26'h2400000 :
        {{3{seed[22]}}, seed[22:0]};
    sample_i <= s;
    exp_q.push_back(fmt(s));
    cfg_i <= {3'h5, seed[28:24], 1'b1, seed[29], 2'(k), 1'b1, 3'h0};
    ext_sck_i <= k[0];
    conv_clk_sel_i <= 2'(k);
  endtask

  // Sampled before the edge's updates, so the period count is exact
  always @(posedge clk_sys_i) begin
    fclk_q <= link.fclk;
    fclk_cnt <= (link.fclk && !fclk_q) ? 1 : fclk_cnt + 1;
    if (link.fclk && !fclk_q) begin
      fclk_per <= fclk_cnt;
    end
  end

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // ==========================================================
  // Sequence
  initial begin
    int k;
    logic [15:0] c;
    logic hold;
    n_fail = 0;
    comparisons = 0;
    seed = 32'hCF058150;
    rst_n_i = 1'b0;
    read_en_i = 1'b0;
    word_ready_i = 1'b0;
    next_in(0);
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(negedge clk_sys_i);
    check_val("mux_pos", 32'h0, 32'(mux_pos_sel_o));
    check_val("mux_neg", 32'h1, 32'(mux_neg_sel_o));
    check_val("rejection", 32'h0, 32'(rejection_o));
    check_bit("speed_2x", 1'b0, speed_2x_o);
    check_bit("converting", 1'b1, converting_o);
    @(posedge clk_sys_i);
    read_en_i <= 1'b1;
    for (k = 0; k < 8; k++) begin
      wait_cs(1'b0);
      repeat (12) @(negedge clk_sys_i);
      check_bit("status_busy", 1'b1, link.sdo);
      check_bit("sdo_oe_n", 1'b0, link.dev_sdo_oe_n);
      check_bit("int_mode", ~ext_sck_i, int_sck_mode_o);
      wait_cs(1'b1);
      check_bit("ext_clk", conv_clk_sel_i != 2'h0, ext_conv_clk_o);
      if (conv_clk_sel_i != 2'h0) begin
        check_bit("fclk_per", 1'b1, in_tol(fclk_per, conv_clk_sel_i));
      end
      c = cfg_i;
      @(posedge clk_sys_i);
      next_in(k + 1);
      repeat (20) @(negedge clk_sys_i);
      check_val("mux_pos", 32'({1'b0, c[10:8], c[11]}),
                32'(mux_pos_sel_o));
      check_val("mux_neg", c[12] ? 32'h10 : 32'({1'b0, c[10:8], ~c[11]}),
                32'(mux_neg_sel_o));
      check_bit("temp", c[6], temp_sel_o);
      check_val("rejection", 32'(c[5:4]), 32'(rejection_o));
      check_bit("speed_2x", 1'b1, speed_2x_o);
      check_bit("converting", 1'b1, converting_o);
    end
    // A full buffer must hold off the next read
    hold = 1'b1;
    repeat (6000) begin
      @(negedge clk_sys_i);
      if (link.cs_n !== 1'b1) begin
        hold = 1'b0;
      end
    end
    check_bit("full_hold", 1'b1, hold);
    read_en_i <= 1'b0;
    for (k = 0; k < 8; k++) begin
      check_bit("word_valid", 1'b1, word_valid_o);
      check_val("word", exp_q.pop_front(), word_o);
      @(posedge clk_sys_i);
      word_ready_i <= 1'b1;
      @(posedge clk_sys_i);
      word_ready_i <= 1'b0;
      @(negedge clk_sys_i);
    end
    check_bit("word_valid", 1'b0, word_valid_o);
    report_and_stop();
  end
endmodule

`default_nettype wire
